// ===== hdl/utc_pkg.sv
// Package of register offsets, field positions, reset values and timing for the USART transmit control block.
package utc_pkg;
  // Register byte offsets on the APB bus.
  localparam logic [7:0] UTC_OFF_TSC = 8'h00;
  localparam logic [7:0] UTC_OFF_RSC = 8'h04;
  localparam logic [7:0] UTC_OFF_BAUD = 8'h08;
  localparam logic [7:0] UTC_OFF_TXDATA = 8'h0C;
  localparam logic [7:0] UTC_OFF_RXDATA = 8'h10;
  localparam logic [7:0] UTC_OFF_PORTDIR = 8'h14;
  localparam logic [7:0] UTC_OFF_STATUS = 8'h18;

  // Field positions in transmit_status_control.
  localparam int UTC_TSC_CLKSRC = 7;
  localparam int UTC_TSC_NINE = 6;
  localparam int UTC_TSC_TRANSMITTER_ENABLE = 5;
  localparam int UTC_TSC_SYNC = 4;
  localparam int UTC_TSC_HISPD = 2;
  localparam int UTC_TSC_TRMT = 1;
  localparam int UTC_TSC_NINTH = 0;
  localparam logic [7:0] UTC_TSC_WMASK = 8'hF5;

  // Field positions in receive_status_control.
  localparam int UTC_RSC_SERIAL_PORT_ENABLE = 7;
  localparam int UTC_RSC_RXNINE = 6;
  localparam int UTC_RSC_SINGLE_RECEIVE_ENABLE = 5;
  localparam int UTC_RSC_CONTINUOUS_RECEIVE_ENABLE = 4;
  localparam int UTC_RSC_RXNINTH = 0;
  localparam logic [7:0] UTC_RSC_WMASK = 8'hF0;

  // Field positions in port_direction_bits and in the status register.
  localparam int UTC_DIR_TXCK = 6;
  localparam int UTC_DIR_RXDT = 7;
  localparam int UTC_ST_HOLD_EMPTY = 0;
  localparam int UTC_ST_RX_FULL = 1;

  // Values after reset.
  localparam logic [7:0] UTC_TSC_RESET = 8'h00;
  localparam logic [7:0] UTC_RSC_RESET = 8'h00;
  localparam logic [7:0] UTC_BAUD_RESET = 8'h00;
  localparam logic [7:0] UTC_DIR_RESET = 8'hC0;

  // Baud ticks per serial bit, as last tick index, the tick from which the sync master clock is high, and the last data bit index.
  localparam logic [5:0] UTC_LAST_SYNC = 6'h03;
  localparam logic [5:0] UTC_LAST_ASYNC_HI = 6'h0F;
  localparam logic [5:0] UTC_LAST_ASYNC_LO = 6'h3F;
  localparam logic [5:0] UTC_SCLK_HIGH_FROM = 6'h02;
  localparam logic [3:0] UTC_LAST_BIT8 = 4'h7;
  localparam logic [3:0] UTC_LAST_BIT9 = 4'h8;

  // Transmit and receive sequencer states.
  typedef enum logic [1:0] {
    UTC_TX_IDLE = 2'b00,
    UTC_TX_START = 2'b01,
    UTC_TX_BITS = 2'b10,
    UTC_TX_STOP = 2'b11
  } utc_tx_state_t;

  typedef enum logic [1:0] {
    UTC_RX_IDLE = 2'b00,
    UTC_RX_START = 2'b01,
    UTC_RX_BITS = 2'b10,
    UTC_RX_STOP = 2'b11
  } utc_rx_state_t;
endpackage

// ===== hdl/utc_baud_gen.sv
// Baud generator: free running 8-bit divider that emits a one-cycle tick.
`timescale 1ns/1ps
module utc_baud_gen
  import utc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [7:0] divisor,
  input wire logic restart,
  output logic tick
);
  logic [7:0] count_reg;

  // Count down from the divisor; a restart clears the timer so a new rate takes hold at once.
  always_ff @(posedge sys_clk) begin
    if (rst || restart) begin
      count_reg <= 8'h00;
      tick <= 1'b0;
    end else if (count_reg == 8'h00) begin
      count_reg <= divisor;
      tick <= 1'b1;
    end else begin
      count_reg <= count_reg - 8'h01;
      tick <= 1'b0;
    end
  end
endmodule // utc_baud_gen

// ===== hdl/utc_top.sv
// USART with APB registers, asynchronous and synchronous master/slave transmit and receive.
`timescale 1ns/1ps
module utc_top
  import utc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic txck_in,
  output logic txck_out,
  output logic txck_oe,
  input wire logic rxdt_in,
  output logic rxdt_out,
  output logic rxdt_oe
);
  // Last tick index of one serial bit for the current mode.
  function automatic logic [5:0] bit_last(input logic sync, input logic hispd);
    if (sync) begin
      bit_last = UTC_LAST_SYNC;
    end else if (hispd) begin
      bit_last = UTC_LAST_ASYNC_HI;
    end else begin
      bit_last = UTC_LAST_ASYNC_LO;
    end
  endfunction

  logic [7:0] tsc_reg;
  logic [7:0] rsc_reg;
  logic [7:0] baud_reg;
  logic [7:0] dir_reg;
  logic [8:0] hold_reg;
  logic hold_full_reg;
  logic [8:0] rxbuf_reg;
  logic rx_full_reg;
  logic [8:0] tsr_reg;
  logic [8:0] rsr_reg;
  logic [5:0] tx_tcnt_reg;
  logic [5:0] rx_tcnt_reg;
  logic [3:0] tx_bitn_reg;
  logic [3:0] rx_bitn_reg;
  utc_tx_state_t tx_state_reg;
  utc_rx_state_t rx_state_reg;
  logic ck_sync1, ck_sync2, ck_sync3, ck_lvl_reg;
  logic dt_sync1, dt_sync2, dt_sync3, dt_lvl_reg;
  logic tick;

  // Decoded control fields.
  logic serial_port_enable, sync, master, nine, transmitter_enable, rx_nine, rx_on;
  assign serial_port_enable = rsc_reg[UTC_RSC_SERIAL_PORT_ENABLE];
  assign sync = tsc_reg[UTC_TSC_SYNC];
  assign master = tsc_reg[UTC_TSC_CLKSRC];
  assign nine = tsc_reg[UTC_TSC_NINE];
  assign transmitter_enable = tsc_reg[UTC_TSC_TRANSMITTER_ENABLE];
  assign rx_nine = rsc_reg[UTC_RSC_RXNINE];
  // Asynchronous reception follows only the continuous enable; synchronous takes either.
  assign rx_on = serial_port_enable && (rsc_reg[UTC_RSC_CONTINUOUS_RECEIVE_ENABLE] || (sync && rsc_reg[UTC_RSC_SINGLE_RECEIVE_ENABLE]));

  // APB decode; writes and reads complete at the edge where pready is high.
  logic acc, wr_ok, rd_ok, mapped;
  assign acc = psel && penable && pready;
  assign wr_ok = acc && pwrite && !pslverr;
  assign rd_ok = acc && !pwrite && !pslverr;
  assign mapped = (paddr == UTC_OFF_TSC) || (paddr == UTC_OFF_RSC) || (paddr == UTC_OFF_BAUD) ||
                  (paddr == UTC_OFF_TXDATA) || (paddr == UTC_OFF_RXDATA) ||
                  (paddr == UTC_OFF_PORTDIR) || (paddr == UTC_OFF_STATUS);

  utc_baud_gen u_baud (
    .sys_clk(sys_clk),
    .rst(rst),
    .divisor(baud_reg),
    .restart(wr_ok && paddr == UTC_OFF_BAUD),
    .tick(tick)
  );

  // Pin synchronisers; a level counts only once the second and third stages agree.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      {ck_sync1, ck_sync2, ck_sync3, ck_lvl_reg} <= 4'h0;
      {dt_sync1, dt_sync2, dt_sync3, dt_lvl_reg} <= 4'hF;
    end else begin
      ck_sync1 <= txck_in;
      ck_sync2 <= ck_sync1;
      ck_sync3 <= ck_sync2;
      dt_sync1 <= rxdt_in;
      dt_sync2 <= dt_sync1;
      dt_sync3 <= dt_sync2;
      if (ck_sync2 == ck_sync3) begin
        ck_lvl_reg <= ck_sync3;
      end
      if (dt_sync2 == dt_sync3) begin
        dt_lvl_reg <= dt_sync3;
      end
    end
  end

  logic ck_rise, ck_fall, dt_fall;
  assign ck_rise = (ck_sync2 == ck_sync3) && ck_sync3 && !ck_lvl_reg;
  assign ck_fall = (ck_sync2 == ck_sync3) && !ck_sync3 && ck_lvl_reg;
  // The data line is judged alone; gating it by the clock pin would lose start bits in full duplex.
  assign dt_fall = (dt_sync2 == dt_sync3) && !dt_sync3 && dt_lvl_reg;

  // Bit-time strobes: baud ticks for async and master, external clock edges for slave.
  logic tx_adv, rx_mid, rx_smp, tx_abort, tx_load;
  logic [5:0] last;
  assign last = bit_last(sync, tsc_reg[UTC_TSC_HISPD]);
  assign tx_adv = (sync && !master) ? ck_fall : (tick && tx_tcnt_reg == last);
  assign rx_mid = tick && rx_tcnt_reg == (last >> 1);
  assign rx_smp = (sync && !master) ? ck_rise : (tick && rx_tcnt_reg == last);
  // Synchronous receive wins over transmit since the data line is shared.
  assign tx_abort = !serial_port_enable || !transmitter_enable || (sync && rx_on);
  assign tx_load = !tx_abort && hold_full_reg && tx_state_reg == UTC_TX_IDLE;

  // Control registers; a software write to the receive enables beats the hardware clear.
  logic rx_done, rx_single_end;
  logic [8:0] rsr_shift;
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      tsc_reg <= UTC_TSC_RESET;
      rsc_reg <= UTC_RSC_RESET;
      baud_reg <= UTC_BAUD_RESET;
      dir_reg <= UTC_DIR_RESET;
    end else begin
      // The clear comes first so that a write to the receive control register in the same cycle overrides it.
      if (rx_single_end) begin
        rsc_reg[UTC_RSC_SINGLE_RECEIVE_ENABLE] <= 1'b0;
      end
      if (wr_ok) begin
        case (paddr)
          UTC_OFF_TSC: tsc_reg <= pwdata[7:0] & UTC_TSC_WMASK;
          UTC_OFF_RSC: rsc_reg <= pwdata[7:0] & UTC_RSC_WMASK;
          UTC_OFF_BAUD: baud_reg <= pwdata[7:0];
          UTC_OFF_PORTDIR: dir_reg <= pwdata[7:0];
          default: tsc_reg <= tsc_reg;
        endcase
      end
    end
  end

  // Transmit holding word; the ninth bit is latched with the data. Writes while full are dropped.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      hold_reg <= 9'h000;
      hold_full_reg <= 1'b0;
    end else if (wr_ok && paddr == UTC_OFF_TXDATA && !hold_full_reg) begin
      hold_reg <= {tsc_reg[UTC_TSC_NINTH], pwdata[7:0]};
      hold_full_reg <= 1'b1;
    end else if (tx_load) begin
      hold_full_reg <= 1'b0;
    end
  end

  // Transmit sequencer: data LSB first, optional ninth bit, with start and stop bits in async only.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      tx_state_reg <= UTC_TX_IDLE;
      tsr_reg <= 9'h1FF;
      tx_tcnt_reg <= 6'h00;
      tx_bitn_reg <= 4'h0;
    end else if (tx_abort) begin
      tx_state_reg <= UTC_TX_IDLE;
      tsr_reg <= 9'h1FF;
    end else begin
      if (tick) begin
        tx_tcnt_reg <= (tx_tcnt_reg == last) ? 6'h00 : tx_tcnt_reg + 6'h01;
      end
      case (tx_state_reg)
        UTC_TX_IDLE: begin
          if (tx_load) begin
            tsr_reg <= hold_reg;
            tx_tcnt_reg <= 6'h00;
            tx_bitn_reg <= 4'h0;
            tx_state_reg <= sync ? UTC_TX_BITS : UTC_TX_START;
          end
        end
        UTC_TX_START: begin
          if (tx_adv) begin
            tx_state_reg <= UTC_TX_BITS;
          end
        end
        UTC_TX_BITS: begin
          if (tx_adv) begin
            tsr_reg <= {1'b1, tsr_reg[8:1]};
            tx_bitn_reg <= tx_bitn_reg + 4'h1;
            if (tx_bitn_reg == (nine ? UTC_LAST_BIT9 : UTC_LAST_BIT8)) begin
              tx_state_reg <= sync ? UTC_TX_IDLE : UTC_TX_STOP;
            end
          end
        end
        UTC_TX_STOP: begin
          if (tx_adv) begin
            tx_state_reg <= UTC_TX_IDLE;
          end
        end
        default: tx_state_reg <= UTC_TX_IDLE;
      endcase
    end
  end

  // Receive sequencer; in async it runs beside the transmitter on its own line.
  assign rsr_shift = {dt_lvl_reg, rsr_reg[8:1]};
  assign rx_done = (rx_state_reg == UTC_RX_STOP && rx_smp) ||
                   (sync && rx_state_reg == UTC_RX_BITS && rx_smp &&
                    rx_bitn_reg == (rx_nine ? UTC_LAST_BIT9 : UTC_LAST_BIT8));
  assign rx_single_end = rx_done && sync && !rsc_reg[UTC_RSC_CONTINUOUS_RECEIVE_ENABLE];

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rx_state_reg <= UTC_RX_IDLE;
      rsr_reg <= 9'h000;
      rx_tcnt_reg <= 6'h00;
      rx_bitn_reg <= 4'h0;
    end else if (!rx_on) begin
      rx_state_reg <= UTC_RX_IDLE;
    end else begin
      if (tick) begin
        rx_tcnt_reg <= (rx_tcnt_reg == last) ? 6'h00 : rx_tcnt_reg + 6'h01;
      end
      case (rx_state_reg)
        UTC_RX_IDLE: begin
          rx_tcnt_reg <= 6'h00;
          rx_bitn_reg <= 4'h0;
          if (sync ? (tx_state_reg == UTC_TX_IDLE) : dt_fall) begin
            rx_state_reg <= sync ? UTC_RX_BITS : UTC_RX_START;
          end
        end
        UTC_RX_START: begin
          if (rx_mid) begin
            rx_tcnt_reg <= 6'h00;
            rx_state_reg <= dt_lvl_reg ? UTC_RX_IDLE : UTC_RX_BITS;
          end
        end
        UTC_RX_BITS: begin
          if (rx_smp) begin
            rsr_reg <= rsr_shift;
            rx_bitn_reg <= rx_bitn_reg + 4'h1;
            if (rx_bitn_reg == (rx_nine ? UTC_LAST_BIT9 : UTC_LAST_BIT8)) begin
              rx_state_reg <= sync ? UTC_RX_IDLE : UTC_RX_STOP;
            end
          end
        end
        UTC_RX_STOP: begin
          if (rx_smp) begin
            rx_state_reg <= UTC_RX_IDLE;
          end
        end
        default: rx_state_reg <= UTC_RX_IDLE;
      endcase
    end
  end

  // Receive buffer; a new word arriving during a read of the buffer keeps the full flag set.
  logic [8:0] rx_word;
  always_comb begin
    if (sync) begin
      rx_word = rx_nine ? rsr_shift : {1'b0, rsr_shift[8:1]};
    end else begin
      rx_word = rx_nine ? rsr_reg : {1'b0, rsr_reg[8:1]};
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rxbuf_reg <= 9'h000;
      rx_full_reg <= 1'b0;
    end else if (rx_done) begin
      rxbuf_reg <= rx_word;
      rx_full_reg <= 1'b1;
    end else if (rd_ok && paddr == UTC_OFF_RXDATA) begin
      rx_full_reg <= 1'b0;
    end
  end

  // APB answer: one wait state, then pready with registered data and error.
  logic [31:0] rd_mux;
  always_comb begin
    case (paddr)
      UTC_OFF_TSC: rd_mux = {24'h0000_00, tsc_reg[7:2], (tx_state_reg == UTC_TX_IDLE), tsc_reg[0]};
      UTC_OFF_RSC: rd_mux = {24'h0000_00, rsc_reg[7:1], rxbuf_reg[8]};
      UTC_OFF_BAUD: rd_mux = {24'h0000_00, baud_reg};
      UTC_OFF_RXDATA: rd_mux = {23'h00_0000, rxbuf_reg};
      UTC_OFF_PORTDIR: rd_mux = {24'h0000_00, dir_reg};
      UTC_OFF_STATUS: rd_mux = {30'h0000_0000, rx_full_reg, !hold_full_reg};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else if (psel && penable && !pready) begin
      pready <= 1'b1;
      pslverr <= !mapped;
      prdata <= pwrite ? 32'h0000_0000 : rd_mux;
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // Pin drive, registered. The clock/transmit pin follows its direction bit except as a sync slave; in sync mode the
  // data pin is driven only while a frame is being shifted out.
  logic sclk, tx_line;
  assign sclk = sync && master &&
                ((tx_state_reg == UTC_TX_BITS && tx_tcnt_reg >= UTC_SCLK_HIGH_FROM) ||
                 (rx_state_reg == UTC_RX_BITS && rx_tcnt_reg >= UTC_SCLK_HIGH_FROM));
  assign tx_line = (tx_state_reg == UTC_TX_START) ? 1'b0 :
                   (tx_state_reg == UTC_TX_BITS) ? tsr_reg[0] : 1'b1;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      txck_out <= 1'b1;
      txck_oe <= 1'b0;
      rxdt_out <= 1'b1;
      rxdt_oe <= 1'b0;
    end else begin
      txck_out <= sync ? sclk : tx_line;
      txck_oe <= serial_port_enable && !dir_reg[UTC_DIR_TXCK] && (!sync || master);
      rxdt_out <= tx_line;
      rxdt_oe <= serial_port_enable && sync && tx_state_reg == UTC_TX_BITS;
    end
  end
endmodule // utc_top

// ===== tb/utc_props.sv
// Checker of the transmit control block's port behaviour, bound to its top module.
`timescale 1ns/1ps
module utc_props
  import utc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic txck_out,
  input wire logic txck_oe,
  input wire logic rxdt_oe
);
  logic [7:0] tsc_reg;
  logic [7:0] rsc_reg;
  logic [7:0] dir_reg;
  logic [7:0] baud_reg;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  // Shadow copies of the control registers; only completed, accepted writes count.
  wire wr_done = psel && penable && pready && pwrite && !pslverr;
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      tsc_reg <= UTC_TSC_RESET;
      rsc_reg <= UTC_RSC_RESET;
      dir_reg <= UTC_DIR_RESET;
      baud_reg <= UTC_BAUD_RESET;
    end else if (wr_done) begin
      if (paddr == UTC_OFF_TSC) tsc_reg <= pwdata[7:0];
      if (paddr == UTC_OFF_RSC) rsc_reg <= pwdata[7:0];
      if (paddr == UTC_OFF_PORTDIR) dir_reg <= pwdata[7:0];
      if (paddr == UTC_OFF_BAUD) baud_reg <= pwdata[7:0];
    end
  end
  // Mode decode; the three-cycle antecedents below absorb the registered pin outputs.
  wire is_sync = tsc_reg[UTC_TSC_SYNC];
  wire is_master = tsc_reg[UTC_TSC_CLKSRC];
  wire pins_on = rsc_reg[UTC_RSC_SERIAL_PORT_ENABLE] && !dir_reg[UTC_DIR_TXCK];
  a_ready_one_wait: assert property (psel && !penable |=> !pready ##1 pready)
    else $error("pready not in second access cycle");
  a_ready_single: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_unmapped_refused: assert property (pready && paddr > UTC_OFF_STATUS |-> pslverr && prdata == 32'h0000_0000)
    else $error("unmapped access not refused");
  a_serial_port_enable_quiet: assert property ((!rsc_reg[UTC_RSC_SERIAL_PORT_ENABLE]) [*3] |-> !txck_oe && !rxdt_oe)
    else $error("pin driven while port disabled");
  a_async_split: assert property ((!is_sync) [*3] |-> !rxdt_oe)
    else $error("data pin driven in asynchronous mode");
  a_master_drives: assert property ((pins_on && (!is_sync || is_master)) [*3] |-> txck_oe)
    else $error("clock pin not driven by master");
  a_slave_clock_in: assert property ((is_sync && !is_master) [*3] |-> !txck_oe)
    else $error("slave drives clock pin");
  a_master_half: assert property ($rose(txck_out) && is_sync && is_master && baud_reg == 8'h00
    |=> txck_out ##1 !txck_out)
    else $error("master clock high phase not two ticks");
  a_rx_blocks_tx: assert property ((is_sync && rsc_reg[UTC_RSC_CONTINUOUS_RECEIVE_ENABLE]) [*3] |-> !rxdt_oe)
    else $error("transmit while receive enabled");
  a_transmitter_enable_gate: assert property ((!tsc_reg[UTC_TSC_TRANSMITTER_ENABLE]) [*3] |-> !rxdt_oe && (is_sync || txck_out))
    else $error("transmit while disabled");
  c_async_start: cover property ($fell(txck_out) && !is_sync);
  c_master_shift: cover property (rxdt_oe && is_master);
  c_slave_shift: cover property (rxdt_oe && !is_master);
endmodule // utc_props

bind utc_top utc_props utc_props_inst (
  .sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .txck_out(txck_out), .txck_oe(txck_oe), .rxdt_oe(rxdt_oe)
);

// ===== tb/utc_peer.sv
// Behavioural serial peer: frame receiver for both modes and clock source in slave mode.
`timescale 1ns/1ps
module utc_peer (
  input wire logic sys_clk,
  input wire logic clr,
  input wire logic sync_mode,
  input wire logic nine,
  input wire logic sck_run,
  input wire logic txck,
  input wire logic rxdt,
  input wire logic rxdt_oe,
  input int bit_len,
  output logic sck,
  output logic [8:0] word = 9'h000,
  output int nbits = 0,
  output logic stop_bit = 1'b0
);
  logic prev = 1'b1;
  logic busy = 1'b0;
  int cnt = 0;
  // Link clock of 160 ns, held low between frames; it starts half a period after the run
  // request, away from the system clock edge, so the first data bit is always set up.
  initial begin
    sck = 1'b0;
    forever begin
      wait (sck_run);
      #82;
      while (sck_run) begin
        sck = ~sck;
        #80;
      end
      sck = 1'b0;
    end
  end
  // Sync bits are taken on the rising clock; async bits at mid-bit, one bit length apart.
  always @(posedge sys_clk) begin
    prev <= txck;
    if (clr) begin
      nbits <= 0;
      busy <= 1'b0;
    end else if (sync_mode) begin
      if (rxdt_oe && txck && !prev && nbits < 9) begin
        word[nbits] <= rxdt;
        nbits <= nbits + 1;
      end
    end else if (!busy) begin
      if (prev && !txck) begin
        busy <= 1'b1;
        cnt <= bit_len + bit_len / 2 - 1;
      end
    end else if (cnt > 0) begin
      cnt <= cnt - 1;
    end else if (nbits < (nine ? 9 : 8)) begin
      word[nbits] <= txck;
      nbits <= nbits + 1;
      cnt <= bit_len - 1;
    end else begin
      stop_bit <= txck;
      busy <= 1'b0;
    end
  end
endmodule // utc_peer

// ===== tb/usart_transmit_control_tb.sv
// Self-checking bench of the transmit control block against the serial peer model.
`timescale 1ns/1ps
module usart_transmit_control_tb
  import utc_pkg::*;
;
  typedef struct {logic w; logic [7:0] a; logic [7:0] d; logic [7:0] x; logic e;} utc_row_t;
  logic sys_clk, rst, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic txck_out, txck_oe, rxdt_out, rxdt_oe;
  logic clr, sync_mode, nine, slave, sck_run, sck, stop_bit;
  logic [8:0] word;
  int nbits;
  int bit_len;
  int bad_count = 0;
  int cmp_count = 0;
  // Both pins have pull-ups; in slave mode the peer owns the clock pin.
  wire txck_w = txck_oe ? txck_out : (slave ? sck : 1'b1);
  wire rxdt_w = rxdt_oe ? rxdt_out : 1'b1;
  // Register rows: write flag, address, write data, expected read data, expected error.
  utc_row_t rows[13] = '{
    '{1'b0, UTC_OFF_TSC, 8'h00, 8'h02, 1'b0}, '{1'b0, UTC_OFF_RSC, 8'h00, 8'h00, 1'b0},
    '{1'b0, UTC_OFF_PORTDIR, 8'h00, 8'hC0, 1'b0}, '{1'b0, UTC_OFF_STATUS, 8'h00, 8'h01, 1'b0},
    '{1'b0, UTC_OFF_BAUD, 8'h00, 8'h00, 1'b0}, '{1'b0, UTC_OFF_TXDATA, 8'h00, 8'h00, 1'b0},
    '{1'b1, UTC_OFF_TSC, 8'hFF, 8'h00, 1'b0}, '{1'b0, UTC_OFF_TSC, 8'h00, 8'hF7, 1'b0},
    '{1'b1, 8'h1C, 8'h5A, 8'h00, 1'b1}, '{1'b0, 8'h1C, 8'h00, 8'h00, 1'b1},
    '{1'b1, UTC_OFF_RSC, 8'h80, 8'h00, 1'b0}, '{1'b1, UTC_OFF_PORTDIR, 8'h80, 8'h00, 1'b0},
    '{1'b0, UTC_OFF_PORTDIR, 8'h00, 8'h80, 1'b0}};
  utc_top utc_top_inst (.sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .txck_in(txck_w), .txck_out(txck_out), .txck_oe(txck_oe), .rxdt_in(rxdt_w), .rxdt_out(rxdt_out),
    .rxdt_oe(rxdt_oe));
  utc_peer utc_peer_inst (.sys_clk(sys_clk), .clr(clr), .sync_mode(sync_mode), .nine(nine),
    .sck_run(sck_run), .txck(txck_w), .rxdt(rxdt_w), .rxdt_oe(rxdt_oe), .sck(sck), .word(word),
    .nbits(nbits), .stop_bit(stop_bit), .bit_len(bit_len));
  // Clock of 125 MHz.
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One APB transfer; it waits for pready as long as it takes, the watchdog ends a dead slave.
  task automatic acc(input utc_row_t q);
    @(posedge sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= q.w;
    paddr <= q.a;
    pwdata <= {24'h00_0000, q.d};
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
    end while (pready !== 1'b1);
    chk({31'h0, pslverr}, {31'h0, q.e});
    if (!q.w) chk(prdata, {24'h00_0000, q.x});
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    utc_row_t q;
    q = '{1'b1, a, d, 8'h00, 1'b0};
    acc(q);
  endtask
  // Sends one word and compares what the peer captured on the pins.
  task automatic frame(input logic [7:0] tsc, input logic [7:0] dat, input int nb, input logic [8:0] wx);
    int n;
    sync_mode <= tsc[UTC_TSC_SYNC];
    slave <= tsc[UTC_TSC_SYNC] && !tsc[UTC_TSC_CLKSRC];
    nine <= tsc[UTC_TSC_NINE];
    bit_len <= tsc[UTC_TSC_HISPD] ? int'(UTC_LAST_ASYNC_HI) + 1 : int'(UTC_LAST_ASYNC_LO) + 1;
    clr <= 1'b1;
    wr(UTC_OFF_TSC, tsc);
    clr <= 1'b0;
    wr(UTC_OFF_TXDATA, dat);
    // The slave clock starts only once the word is loaded, so no edge can skip the first bit.
    sck_run <= tsc[UTC_TSC_SYNC] && !tsc[UTC_TSC_CLKSRC];
    n = 0;
    while (nbits < nb && n < 2000) begin
      @(posedge sys_clk);
      n++;
    end
    repeat (80) @(posedge sys_clk);
    sck_run <= 1'b0;
    chk(nbits, nb);
    chk({23'h0, nb == 9 ? word : {1'b0, word[7:0]}}, {23'h0, wx});
    if (!tsc[UTC_TSC_SYNC]) chk({31'h0, stop_bit}, 32'h0000_0001);
    $display("frame test with control %h done", tsc);
  endtask
  task automatic end_sim();
    $display("compares %0d, mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // Main sequence: register table, frames in every mode, blocked transmit, second reset.
  initial begin
    rst = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00; pwdata = 32'h0000_0000;
    clr = 1'b1; sync_mode = 1'b0; nine = 1'b0; slave = 1'b0; sck_run = 1'b0;
    bit_len = 16;
    repeat (16) @(posedge sys_clk);
    rst <= 1'b0;
    foreach (rows[i]) acc(rows[i]);
    $display("register table test done");
    frame(8'h65, 8'hA5, 9, 9'h1A5);
    frame(8'h20, 8'h3C, 8, 9'h03C);
    frame(8'hB0, 8'h5A, 8, 9'h05A);
    frame(8'hF1, 8'hC3, 9, 9'h1C3);
    frame(8'h31, 8'h96, 8, 9'h096);
    clr <= 1'b1;
    wr(UTC_OFF_TSC, 8'h90);
    clr <= 1'b0;
    wr(UTC_OFF_TXDATA, 8'h22);
    repeat (100) @(posedge sys_clk);
    chk(nbits, 0);
    wr(UTC_OFF_RSC, 8'h90);
    wr(UTC_OFF_TSC, 8'hB0);
    repeat (100) @(posedge sys_clk);
    chk(nbits, 0);
    $display("blocked transmit test done");
    rst <= 1'b1;
    repeat (16) @(posedge sys_clk);
    rst <= 1'b0;
    acc(rows[0]);
    acc(rows[1]);
    chk({31'h0, txck_oe}, 32'h0000_0000);
    $display("second reset test done");
    end_sim();
  end
  // Watchdog: the full sequence needs about 1700 cycles.
  initial begin
    repeat (20000) @(posedge sys_clk);
    bad_count++;
    $display("mismatch at %0t: watchdog expired", $time);
    end_sim();
  end
endmodule // usart_transmit_control_tb
